/* src/addr_mode_pkg.sv */
// Shared types and constants for the operand addressing decoder.
// Assumes one CPU clock, a synchronous memory bus with a ready-style ack,
// and an instruction sequencer that names the base mode of each opcode.
`default_nettype none

package addr_mode_pkg;

    // ****************************************************************
    // Widths and fixed values
    // ****************************************************************
    localparam int          ADDR_W        = 16;      // 64 Kbyte address space.
    localparam int          DATA_W        = 8;       // Byte-wide memory bus.
    localparam int          BIT_POS_LSB   = 1;       // Bit field sits in opcode bits 3..1.
    localparam logic [1:0]  MASK_LEVEL_SET = 2'h3;   // Interrupt mask after the set operation.
    localparam logic [1:0]  MASK_LEVEL_CLR = 2'h0;   // Interrupt mask after the clear operation.
    localparam logic [1:0]  MASK_RESET     = 2'h3;   // Mask level held after reset.
    localparam logic [7:0]  PAGE_ZERO_HI   = 8'h00;  // Upper byte of every short address.
    localparam logic [15:0] ADDR_RESET     = 16'h0000; // Reset value of address registers.

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    // The seventeen operand addressing modes.
    typedef enum logic [4:0] {
        MODE_INHERENT, MODE_IMMEDIATE, MODE_DIR_SHORT, MODE_DIR_LONG,
        MODE_IDX_NONE, MODE_IDX_SHORT, MODE_IDX_LONG, MODE_IND_SHORT,
        MODE_IND_LONG, MODE_INDIDX_SHORT, MODE_INDIDX_LONG, MODE_REL_DIR,
        MODE_REL_IND, MODE_BIT_DIR, MODE_BIT_IND, MODE_BITREL_DIR,
        MODE_BITREL_IND
    } addr_mode_t;

    // Inherent operations that this block carries out itself.
    typedef enum logic [2:0] {
        INH_OTHER, SET_INTERRUPT_MASK_OP, CLEAR_INTERRUPT_MASK_OP,
        HALT_OP, WAIT_FOR_INTERRUPT_OP
    } inherent_op_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    // One decode request from the sequencer.
    typedef struct packed {
        logic [7:0]   opcode;               // Opcode byte.
        addr_mode_t   mode;                 // Base mode before prebytes.
        inherent_op_t inh_op;               // Inherent operation kind.
        logic         rmw;                  // Read-modify-write memory instruction.
        logic         second_index_prebyte; // Prebyte 90 seen.
        logic         indirect_mode_prebyte;// Prebyte 92 seen.
        logic [15:0]  pc;                   // Address of the byte after the opcode.
    } decode_req_t;

    // One decode result handed back to the sequencer.
    typedef struct packed {
        addr_mode_t  mode;          // Final mode after prebytes.
        logic [15:0] ea;            // Effective operand address.
        logic [7:0]  operand;       // Immediate operand value.
        logic [15:0] next_pc;       // Address after the last operand byte.
        logic [15:0] target;        // Relative branch target.
        logic [2:0]  bit_pos;       // Bit number for bit modes.
        logic [2:0]  operand_bytes; // Instruction bytes after the opcode.
        logic        illegal;       // Long mode asked for by a memory-to-memory op.
    } decode_result_t;

endpackage : addr_mode_pkg

`default_nettype wire

/* src/addr_mode_decoder.sv */
// Operand addressing decoder of the 8-bit CPU core.
// Assumes the sequencer supplies the opcode, its base mode and prebyte
// flags, and that the memory answers each held request with one ack pulse.
//
// Behaviour
// - Seventeen operand addressing modes supported.
// - Inherent: one byte, no operand fetch.
// - Immediate: next byte is the value.
// - Short direct: one address byte, page zero.
// - Long direct: two address bytes, full space.
// - Indexed: unsigned index plus instruction offset.
// - No-offset indexed: index alone, no fetch.
// - Short indexed: byte offset, sum to 1FE.
// - Long indexed: word offset plus index.
// - Indirect: fetch pointer address, read pointer.
// - Short pointer byte; long pointer word.
// - Indirect indexed: pointer plus index register.
// - Short byte pointer to 1FE; long word.
// - Short direct and indirect modes page zero, fewer bytes.
// - Memory-to-memory ops accept short modes only.
// - Set mask gives level 3, clear 0.
// - Halt stops oscillator; wait until interrupt.
// - Relative adds signed byte offset to PC.
// - Prebyte 90 swaps to second index.
// - Prebyte 92 turns direct into indirect.
`default_nettype none

module addr_mode_decoder
    import addr_mode_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           reset,
    input  wire logic           req_valid,
    output logic                req_ready,
    input  wire decode_req_t    req,
    input  wire logic [7:0]     index_first,
    input  wire logic [7:0]     index_second,
    output logic                result_valid,
    output decode_result_t      result,
    output logic                mem_req,
    output logic [15:0]         mem_addr,
    input  wire logic [7:0]     mem_rdata,
    input  wire logic           mem_ack,
    output logic [1:0]          int_mask_level,
    output logic                osc_stop,
    output logic                wait_mode,
    input  wire logic           wake_event,
    input  wire logic           irq_pending
);

    // ****************************************************************
    // State and registers
    // ****************************************************************
    // Sequence of memory cycles; each fetch state holds mem_req until ack.
    typedef enum logic [2:0] {
        ST_IDLE, ST_OP0, ST_OP1, ST_PTR0, ST_PTR1, ST_OFS, ST_DONE
    } seq_state_t;

    seq_state_t     state_reg, state_next;       // Sequencer state.
    addr_mode_t     mode_reg;                    // Mode after prebyte rewrite.
    logic           use_second_reg;              // Second index selected.
    logic           illegal_reg;                 // Rejected long mode.
    logic [7:0]     opcode_reg;                  // Opcode kept for the bit field.
    logic [15:0]    acc_reg;                     // Address, offset or pointer being built.
    logic [7:0]     ptr_addr_reg;                // Page-zero pointer address.
    logic [7:0]     rel_ofs_reg;                 // Offset of bit-test-and-jump forms.
    logic [15:0]    fetch_addr_reg;              // Next operand byte address.
    logic [15:0]    pc_start_reg;                // First operand byte address.
    logic           result_valid_reg;            // One-cycle completion pulse.
    decode_result_t result_reg;                  // Held result.
    logic [1:0]     mask_reg;                    // Interrupt mask level.
    logic           osc_stop_reg;                // Halt in force.
    logic           wait_reg;                    // Wait in force.

    // ****************************************************************
    // Prebyte rewrite of the base mode
    // ****************************************************************
    // Prebyte 92 maps each direct form onto its indirect twin and the
    // short and long indexed forms onto indirect indexed.
    addr_mode_t eff_mode;
    always_comb begin
        eff_mode = req.mode;
        if (req.indirect_mode_prebyte) begin
            case (req.mode)
                MODE_DIR_SHORT:  eff_mode = MODE_IND_SHORT;
                MODE_DIR_LONG:   eff_mode = MODE_IND_LONG;
                MODE_BIT_DIR:    eff_mode = MODE_BIT_IND;
                MODE_BITREL_DIR: eff_mode = MODE_BITREL_IND;
                MODE_REL_DIR:    eff_mode = MODE_REL_IND;
                MODE_IDX_SHORT:  eff_mode = MODE_INDIDX_SHORT;
                MODE_IDX_LONG:   eff_mode = MODE_INDIDX_LONG;
                default:         eff_mode = req.mode;
            endcase
        end
    end

    // ****************************************************************
    // Mode classification (continuous decodes)
    // ****************************************************************
    // Memory-to-memory instructions may not use any long form.
    wire req_is_long  = (eff_mode == MODE_DIR_LONG) || (eff_mode == MODE_IDX_LONG) ||
                        (eff_mode == MODE_IND_LONG) || (eff_mode == MODE_INDIDX_LONG);
    wire req_illegal  = req.rmw && req_is_long;
    // Inherent and no-offset indexed fetch nothing after the opcode.
    wire req_no_fetch = (eff_mode == MODE_INHERENT) || (eff_mode == MODE_IDX_NONE);

    // Classes of the held mode that steer the fetch sequence and the result arithmetic.
    wire m_word_op  = (mode_reg == MODE_DIR_LONG) || (mode_reg == MODE_IDX_LONG);
    wire m_ptr      = (mode_reg == MODE_IND_SHORT) || (mode_reg == MODE_IND_LONG) ||
                      (mode_reg == MODE_INDIDX_SHORT) || (mode_reg == MODE_INDIDX_LONG) ||
                      (mode_reg == MODE_REL_IND) || (mode_reg == MODE_BIT_IND) ||
                      (mode_reg == MODE_BITREL_IND);
    wire m_ptr_word = (mode_reg == MODE_IND_LONG) || (mode_reg == MODE_INDIDX_LONG);
    wire m_bitrel   = (mode_reg == MODE_BITREL_DIR) || (mode_reg == MODE_BITREL_IND);
    wire m_indexed  = (mode_reg == MODE_IDX_NONE) || (mode_reg == MODE_IDX_SHORT) ||
                      (mode_reg == MODE_IDX_LONG) || (mode_reg == MODE_INDIDX_SHORT) ||
                      (mode_reg == MODE_INDIDX_LONG);
    wire m_relative = (mode_reg == MODE_REL_DIR) || (mode_reg == MODE_REL_IND) || m_bitrel;

    // ****************************************************************
    // Address arithmetic
    // ****************************************************************
    // Prebyte 90 redirects every first-index use to the second index.
    wire [7:0]  index_sel  = use_second_reg ? index_second : index_first;
    // Unsigned add without wrapping at eight bits: short forms reach 1FE.
    wire [15:0] index_sum  = acc_reg + {PAGE_ZERO_HI, index_sel};
    wire [15:0] ea_value   = m_indexed ? index_sum : acc_reg;
    // The branch offset is signed; the base is the address after the instruction.
    wire [7:0]  rel_byte   = m_bitrel ? rel_ofs_reg : acc_reg[7:0];
    wire [15:0] rel_target = fetch_addr_reg + {{8{rel_byte[7]}}, rel_byte};
    wire [15:0] fetch_inc  = fetch_addr_reg + 16'h0001;
    wire [15:0] ptr_page0  = {PAGE_ZERO_HI, ptr_addr_reg};
    wire [15:0] ptr_next   = ptr_page0 + 16'h0001;
    wire [15:0] op_bytes   = fetch_addr_reg - pc_start_reg;

    // ****************************************************************
    // Memory request steering
    // ****************************************************************
    // Operand bytes come from the instruction stream; pointer bytes come
    // from the fetched page-zero pointer address and the byte after it.
    assign mem_req   = (state_reg == ST_OP0) || (state_reg == ST_OP1) ||
                       (state_reg == ST_PTR0) || (state_reg == ST_PTR1) ||
                       (state_reg == ST_OFS);
    assign mem_addr  = (state_reg == ST_PTR0) ? ptr_page0 :
                       (state_reg == ST_PTR1) ? ptr_next  : fetch_addr_reg;
    assign req_ready = (state_reg == ST_IDLE);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Each fetch state waits for its ack; the mode decides the successor.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (req_valid) begin
                    if (req_illegal || req_no_fetch) begin
                        state_next = ST_DONE;
                    end else begin
                        state_next = ST_OP0;
                    end
                end
            end
            ST_OP0: begin
                if (mem_ack) begin
                    if (m_word_op) begin
                        state_next = ST_OP1;
                    end else if (m_ptr) begin
                        state_next = ST_PTR0;
                    end else if (m_bitrel) begin
                        state_next = ST_OFS;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_OP1: begin
                if (mem_ack) begin
                    state_next = ST_DONE;
                end
            end
            ST_PTR0: begin
                if (mem_ack) begin
                    if (m_ptr_word) begin
                        state_next = ST_PTR1;
                    end else if (m_bitrel) begin
                        state_next = ST_OFS;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_PTR1: begin
                if (mem_ack) begin
                    state_next = ST_DONE;
                end
            end
            ST_OFS: begin
                if (mem_ack) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Sequencer state register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Request capture
    // ****************************************************************
    // The request is latched once, so the sequencer may change it while busy.
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_reg       <= MODE_INHERENT;
            use_second_reg <= 1'b0;
            illegal_reg    <= 1'b0;
            opcode_reg     <= 8'h00;
            pc_start_reg   <= ADDR_RESET;
        end else if (req_valid && req_ready) begin
            mode_reg       <= eff_mode;
            use_second_reg <= req.second_index_prebyte;
            illegal_reg    <= req_illegal;
            opcode_reg     <= req.opcode;
            pc_start_reg   <= req.pc;
        end
    end

    // ****************************************************************
    // Operand and pointer assembly
    // ****************************************************************
    // Words arrive high byte first; a byte read clears the high half so
    // that short direct and indirect results land in page zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_reg        <= ADDR_RESET;
            ptr_addr_reg   <= 8'h00;
            rel_ofs_reg    <= 8'h00;
            fetch_addr_reg <= ADDR_RESET;
        end else begin
            if (req_valid && req_ready) begin
                acc_reg        <= ADDR_RESET;
                fetch_addr_reg <= req.pc;
            end else if (mem_ack && (state_reg == ST_OP0)) begin
                acc_reg        <= {PAGE_ZERO_HI, mem_rdata};
                ptr_addr_reg   <= mem_rdata;
                fetch_addr_reg <= fetch_inc;
            end else if (mem_ack && (state_reg == ST_OP1)) begin
                acc_reg        <= {acc_reg[7:0], mem_rdata};
                fetch_addr_reg <= fetch_inc;
            end else if (mem_ack && (state_reg == ST_PTR0)) begin
                acc_reg        <= {PAGE_ZERO_HI, mem_rdata};
            end else if (mem_ack && (state_reg == ST_PTR1)) begin
                acc_reg        <= {acc_reg[7:0], mem_rdata};
            end else if (mem_ack && (state_reg == ST_OFS)) begin
                rel_ofs_reg    <= mem_rdata;
                fetch_addr_reg <= fetch_inc;
            end
        end
    end

    // ****************************************************************
    // Result register
    // ****************************************************************
    // The result is filled in the done state and held until the next one,
    // so the sequencer may sample it late; only the valid flag pulses.
    always_ff @(posedge clk) begin
        if (reset) begin
            result_valid_reg <= 1'b0;
            result_reg       <= '0;
        end else begin
            result_valid_reg <= (state_reg == ST_DONE);
            if (state_reg == ST_DONE) begin
                result_reg.mode          <= mode_reg;
                result_reg.ea            <= ea_value;
                result_reg.operand       <= acc_reg[7:0];
                result_reg.next_pc       <= fetch_addr_reg;
                result_reg.target        <= m_relative ? rel_target : fetch_addr_reg;
                result_reg.bit_pos       <= opcode_reg[BIT_POS_LSB +: 3];
                result_reg.operand_bytes <= op_bytes[2:0];
                result_reg.illegal       <= illegal_reg;
            end
        end
    end

    assign result_valid = result_valid_reg;
    assign result       = result_reg;

    // ****************************************************************
    // Inherent operations handled here
    // ****************************************************************
    // Taken at request time, since inherent instructions need no fetch.
    wire take_inh  = req_valid && req_ready && (eff_mode == MODE_INHERENT);
    wire do_set    = take_inh && (req.inh_op == SET_INTERRUPT_MASK_OP);
    wire do_clr    = take_inh && (req.inh_op == CLEAR_INTERRUPT_MASK_OP);
    wire do_halt   = take_inh && (req.inh_op == HALT_OP);
    wire do_wait   = take_inh && (req.inh_op == WAIT_FOR_INTERRUPT_OP);

    // The mask powers up at the set level so no interrupt slips in
    // before software has prepared its handlers.
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_reg <= MASK_RESET;
        end else if (do_set) begin
            mask_reg <= MASK_LEVEL_SET;
        end else if (do_clr) begin
            mask_reg <= MASK_LEVEL_CLR;
        end
    end

    // Low-power levels: an entry in the same cycle as a wake wins, so a
    // stale wake cannot cancel a fresh halt or wait.
    always_ff @(posedge clk) begin
        if (reset) begin
            osc_stop_reg <= 1'b0;
            wait_reg     <= 1'b0;
        end else begin
            if (do_halt) begin
                osc_stop_reg <= 1'b1;
            end else if (wake_event) begin
                osc_stop_reg <= 1'b0;
            end
            if (do_wait) begin
                wait_reg <= 1'b1;
            end else if (irq_pending) begin
                wait_reg <= 1'b0;
            end
        end
    end

    assign int_mask_level = mask_reg;
    assign osc_stop       = osc_stop_reg;
    assign wait_mode      = wait_reg;

endmodule : addr_mode_decoder

`default_nettype wire

/* dv/addr_mode_decoder_properties.sv */
// Concurrent checks for the operand addressing decoder, bound onto its ports.
// Assumes one CPU clock and the synchronous active-high reset.
`default_nettype none

module addr_mode_decoder_chk
    import addr_mode_pkg::*;
(
    input wire logic           clk,
    input wire logic           reset,
    input wire logic           req_valid,
    input wire logic           req_ready,
    input wire decode_req_t    req,
    input wire logic           result_valid,
    input wire decode_result_t result,
    input wire logic           mem_req,
    input wire logic [15:0]    mem_addr,
    input wire logic           mem_ack,
    input wire logic [1:0]     int_mask_level,
    input wire logic           osc_stop,
    input wire logic           wait_mode
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Properties
    // ****************************************************************
    // A request counts only on an edge where valid and ready meet.
    wire take = req_valid && req_ready;
    wire inh  = take && req.mode == MODE_INHERENT;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_mask_set; inh && req.inh_op == SET_INTERRUPT_MASK_OP |=> int_mask_level == 2'h3; endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask not set");
    property p_mask_clr; inh && req.inh_op == CLEAR_INTERRUPT_MASK_OP |=> int_mask_level == 2'h0; endproperty
    a_mask_clr: assert property (p_mask_clr) else $error("mask not cleared");
    property p_halt; inh && req.inh_op == HALT_OP |=> osc_stop; endproperty
    a_halt: assert property (p_halt) else $error("halt missed");
    property p_wait; inh && req.inh_op == WAIT_FOR_INTERRUPT_OP |=> wait_mode; endproperty
    a_wait: assert property (p_wait) else $error("wait missed");
    // No operand byte may be fetched for a one-byte instruction.
    property p_no_fetch; inh |=> !mem_req ##1 (result_valid && !mem_req && result.operand_bytes == 3'h0); endproperty
    a_no_fetch: assert property (p_no_fetch) else $error("inherent fetched");
    // The address must not move while the memory has not answered.
    property p_addr_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_rmw_long; take && req.rmw && req.mode inside {MODE_DIR_LONG, MODE_IDX_LONG}
        |=> !mem_req ##1 (result_valid && result.illegal); endproperty
    a_rmw_long: assert property (p_rmw_long) else $error("long rmw accepted");
    property p_page0; result_valid && result.mode inside {MODE_DIR_SHORT, MODE_IND_SHORT, MODE_IDX_NONE}
        |-> result.ea[15:8] == 8'h00; endproperty
    a_page0: assert property (p_page0) else $error("short mode off page zero");

    c_stall: cover property (mem_req && !mem_ack ##1 mem_ack);
    c_illegal: cover property (result_valid && result.illegal);
    c_indidx: cover property (result_valid && result.mode == MODE_INDIDX_LONG);
endmodule : addr_mode_decoder_chk

bind addr_mode_decoder addr_mode_decoder_chk u_chk (.clk, .reset, .req_valid, .req_ready, .req, .result_valid,
    .result, .mem_req, .mem_addr, .mem_ack, .int_mask_level, .osc_stop, .wait_mode);

`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the operand addressing decoder.
// Assumes the bench plays the memory, answering each held request with one ack.
`default_nettype none

module tb
    import addr_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           clk = 1'b0, reset = 1'b1, req_valid = 1'b0, mem_ack = 1'b0, wake_event = 1'b0, irq_pending = 1'b0;
    logic [7:0]     index_first = 8'h00, index_second = 8'h00, mem_rdata = 8'h00, o;
    logic           req_ready, result_valid, mem_req, osc_stop, wait_mode;
    logic [15:0]    mem_addr;
    logic [1:0]     int_mask_level;
    decode_req_t    req = '0;
    decode_result_t result;
    int             miscompares = 0, check_count = 0, cycles = 0, lat = 0, wait_cnt = 0;

    addr_mode_decoder DUT (.clk, .reset, .req_valid, .req_ready, .req, .index_first, .index_second,
        .result_valid, .result, .mem_req, .mem_addr, .mem_rdata, .mem_ack, .int_mask_level, .osc_stop,
        .wait_mode, .wake_event, .irq_pending);

    always #2.5 clk = ~clk;

    // Memory holds a fixed scramble of each address, so every byte is known.
    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction : mb

    // Memory answers after lat stall cycles; idle data toggles so stale bytes never match.
    always @(posedge clk) begin
        #1;
        if (mem_req && !mem_ack && wait_cnt >= lat) begin
            mem_ack = 1'b1;
            mem_rdata = mb(mem_addr);
            wait_cnt = 0;
        end else begin
            mem_ack = 1'b0;
            mem_rdata = ~mem_rdata;
            wait_cnt = mem_req ? wait_cnt + 1 : 0;
        end
    end

    // Hang guard, far above the roughly 125 cycles the run needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report();
        if (miscompares == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic cmp(input logic [15:0] g, e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    // One request, held for its taking edge, then a wait for the result pulse.
    task automatic decode(input addr_mode_t m, input logic [7:0] op, input logic [15:0] pc,
                          input logic [2:0] f = 3'h0, input inherent_op_t i = INH_OTHER);
        int n = 0;
        @(posedge clk) #1;
        req = '{op, m, i, f[2], f[1], f[0], pc};
        req_valid = 1'b1;
        @(posedge clk) #1;
        req_valid = 1'b0;
        cmp(req_ready, 1'b0);
        while (result_valid !== 1'b1 && n < 40) begin
            @(posedge clk) #1;
            n++;
        end
        cmp(16'(n < 40), 16'h0001);
    endtask : decode

    task automatic t_inherent();
        decode(MODE_INHERENT, 8'h9a, 16'h0101, 3'h0, CLEAR_INTERRUPT_MASK_OP);
        cmp(int_mask_level, 2'h0);
        cmp(result.next_pc, 16'h0101);
        decode(MODE_INHERENT, 8'h9b, 16'h0102, 3'h0, SET_INTERRUPT_MASK_OP);
        cmp(int_mask_level, 2'h3);
        decode(MODE_INHERENT, 8'h8e, 16'h0103, 3'h0, HALT_OP);
        cmp(osc_stop, 1'b1);
        decode(MODE_INHERENT, 8'h8f, 16'h0104, 3'h0, WAIT_FOR_INTERRUPT_OP);
        cmp(wait_mode, 1'b1);
        wake_event = 1'b1;
        irq_pending = 1'b1;
        @(posedge clk) #1;
        wake_event = 1'b0;
        irq_pending = 1'b0;
        cmp(osc_stop, 1'b0);
        cmp(wait_mode, 1'b0);
    endtask : t_inherent

    task automatic t_direct();
        decode(MODE_DIR_SHORT, 8'hb6, 16'h1234);
        cmp(result.ea, {8'h00, mb(16'h1234)});
        cmp(result.operand_bytes, 3'h1);
        lat = 2;
        decode(MODE_DIR_LONG, 8'hc6, 16'h2000);
        cmp(result.ea, {mb(16'h2000), mb(16'h2001)});
        cmp(result.next_pc, 16'h2002);
        decode(MODE_IMMEDIATE, 8'ha6, 16'h0310);
        cmp(result.operand, mb(16'h0310));
        cmp(result.operand_bytes, 3'h1);
    endtask : t_direct

    task automatic t_indexed();
        index_first = 8'hff;
        index_second = 8'h42;
        decode(MODE_IDX_NONE, 8'hf6, 16'h0500, 3'h2);
        cmp(result.ea, 16'h0042);
        cmp(result.operand_bytes, 3'h0);
        decode(MODE_IDX_SHORT, 8'he6, 16'h005a);
        cmp(result.ea, 16'h01fe);
        decode(MODE_IDX_LONG, 8'hd6, 16'h3000, 3'h2);
        cmp(result.ea, {mb(16'h3000), mb(16'h3001)} + 16'h0042);
    endtask : t_indexed

    // Pointer at 00ff makes the word's second byte come from 0100.
    task automatic t_indirect();
        lat = 1;
        decode(MODE_IND_SHORT, 8'hb6, 16'h005a);
        cmp(result.ea, {8'h00, mb(16'h00ff)});
        decode(MODE_IND_LONG, 8'hc6, 16'h005a);
        cmp(result.ea, {mb(16'h00ff), mb(16'h0100)});
        decode(MODE_INDIDX_LONG, 8'hd6, 16'h005a);
        cmp(result.ea, {mb(16'h00ff), mb(16'h0100)} + 16'h00ff);
        decode(MODE_INDIDX_SHORT, 8'he6, 16'h005a);
        cmp(result.ea, {8'h00, mb(16'h00ff)} + 16'h00ff);
    endtask : t_indirect

    task automatic t_prebyte_rmw();
        decode(MODE_DIR_SHORT, 8'hb6, 16'h1234, 3'h1);
        cmp(result.mode, MODE_IND_SHORT);
        cmp(result.ea, {8'h00, mb({8'h00, mb(16'h1234)})});
        decode(MODE_DIR_LONG, 8'h3c, 16'h2000, 3'h4);
        cmp(result.illegal, 1'b1);
        decode(MODE_DIR_SHORT, 8'h3c, 16'h1234, 3'h4);
        cmp(result.illegal, 1'b0);
    endtask : t_prebyte_rmw

    task automatic t_rel_bit();
        o = mb(16'h0810);
        decode(MODE_REL_DIR, 8'h26, 16'h0810);
        cmp(result.target, 16'h0811 + {{8{o[7]}}, o});
        decode(MODE_BIT_DIR, 8'h1a, 16'h1234);
        cmp(result.bit_pos, 3'h5);
        cmp(result.ea, {8'h00, mb(16'h1234)});
        decode(MODE_BITREL_DIR, 8'h0e, 16'h0810, 3'h1);
        cmp(result.ea, 16'h0018);
        cmp(result.target, 16'h07ce);
    endtask : t_rel_bit

    initial begin
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        t_inherent();
        t_direct();
        t_indexed();
        t_indirect();
        t_prebyte_rmw();
        t_rel_bit();
        final_report();
    end
endmodule : tb

`default_nettype wire
